// file: include/cjx_map.vh
// constants for the conditional jump execute block
`ifndef CJX_MAP_VH
`define CJX_MAP_VH

// ****************************************
// opcodes
// ****************************************
`define CJX_OP_ESC 8'hA5
`define CJX_OP_EQ 8'hA8
`define CJX_OP_GT 8'h38
`define CJX_OP_LE 8'h28
`define CJX_OP_IND 8'h73
`define CJX_OP_BITC 8'h30
`define CJX_OP_CYC 8'h50
`define CJX_OP_BITX 8'hA9
`define CJX_SUB_BITC 5'h06

// ****************************************
// lengths and offsets
// ****************************************
`define CJX_LEN_REL 24'h000002
`define CJX_LEN_BIT 24'h000003
`define CJX_LEN_BITX_BIN 24'h000005
`define CJX_LEN_BITX_SRC 24'h000004
`define CJX_LEN_IND 24'h000001
`define CJX_PC_HI_IND 8'hFF

// ****************************************
// state counts (not taken / taken)
// ****************************************
`define CJX_ST_REL_BIN_NT 4'h2
`define CJX_ST_REL_BIN_TK 4'h5
`define CJX_ST_REL_SRC_NT 4'h1
`define CJX_ST_REL_SRC_TK 4'h4
`define CJX_ST_CYC_NT 4'h1
`define CJX_ST_CYC_TK 4'h4
`define CJX_ST_BIT_NT 4'h2
`define CJX_ST_BIT_TK 4'h5
`define CJX_ST_BITX_BIN_NT 4'h4
`define CJX_ST_BITX_BIN_TK 4'h7
`define CJX_ST_BITX_SRC_NT 4'h3
`define CJX_ST_BITX_SRC_TK 4'h6
`define CJX_ST_IND 4'h5

`endif

// file: core/cjx_cond_eval.v
// branch condition evaluation for the conditional jump group
`timescale 1ns/100ps
`include "cjx_map.vh"

module cjx_cond_eval (
   // decoded instruction
   input wire [7:0] opcode_i,
   input wire bit_form_i,
   // flags and tested bit
   input wire zero_flag_i,
   input wire carry_flag_i,
   input wire test_bit_i,
   // result
   output reg known_o,
   output reg take_o
);

   always @* begin
      known_o = 1'b1;
      take_o = 1'b0;
      if (bit_form_i) begin
         take_o = ~test_bit_i; // RL8
      end else begin
         case (opcode_i)
            `CJX_OP_EQ: take_o = zero_flag_i; // RL1
            `CJX_OP_GT: take_o = ~zero_flag_i & ~carry_flag_i; // RL3
            `CJX_OP_LE: take_o = zero_flag_i | carry_flag_i; // RL4
            `CJX_OP_CYC: take_o = ~carry_flag_i; // RL11
            `CJX_OP_BITC: take_o = ~test_bit_i; // RL8
            `CJX_OP_IND: take_o = 1'b1;
            default: known_o = 1'b0;
         endcase
      end
   end

endmodule

// file: core/cjx_target_calc.v
// relative target adder: next pc plus signed byte offset
`timescale 1ns/100ps

module cjx_target_calc #(
   parameter PC_W = 24
) (
   // operands
   input wire [PC_W-1:0] pc_i,
   input wire [PC_W-1:0] len_i,
   input wire [7:0] rel_i,
   // results
   output wire [PC_W-1:0] next_pc_o,
   output wire [PC_W-1:0] target_o
);

   // sign-extend the offset so backward branches wrap correctly
   wire [PC_W-1:0] rel_ext;

   assign rel_ext = {{(PC_W-8){rel_i[7]}}, rel_i};
   assign next_pc_o = pc_i + len_i;
   assign target_o = next_pc_o + rel_ext;

endmodule

// file: core/cjx_exec.v
// execution unit for the conditional and indirect jump group
`timescale 1ns/100ps
`include "cjx_map.vh"

// Notes on behaviour
// (RL1) jump_if_equal taken when zero flag set
// (RL2) relative form: pc plus 2, then offset
// (RL3) jump_if_greater needs zero and carry clear
// (RL4) jump_if_less_equal taken when zero or carry
// (RL5) indirect: accumulator plus data_pointer into pc low
// (RL6) indirect: pc high byte forced to FF
// (RL7) indirect leaves accumulator, pointer, flags alone
// (RL8) jump_if_bit_clear taken when bit reads zero
// (RL9) bit form: pc plus length, then offset
// (RL10) tested bit is only read, never written
// (RL11) jump_if_carry_clear taken when carry zero
// (RL12) jump_if_carry_clear keeps carry unchanged
// (RL13) carry-clear opcode 50, no escape, 1/4 states
module cjx_exec #(
   parameter PC_W = 24
) (
   // clock and reset
   input wire sys_clk_i,
   input wire srst_i,
   // decoded instruction from fetch
   input wire instr_valid_i,
   input wire binary_mode_i,
   input wire escaped_i,
   input wire [7:0] opcode_i,
   input wire [7:0] byte2_i,
   input wire [7:0] byte3_i,
   input wire [PC_W-1:0] pc_i,
   // core state
   input wire [7:0] acc_i,
   input wire [15:0] data_ptr_i,
   input wire zero_flag_i,
   input wire carry_flag_i,
   input wire test_bit_i,
   // results
   output reg done_o,
   output reg handled_o,
   output reg taken_o,
   output reg [PC_W-1:0] pc_o,
   output reg [3:0] states_o,
   output reg pc_load_o,
   output wire flags_we_o,
   output wire acc_we_o,
   output wire data_pointer_we_o,
   output wire bit_we_o
);

   // ****************************************
   // decode
   // ****************************************
   reg [PC_W-1:0] len;
   reg [7:0] rel;
   reg is_ind;
   reg is_bitx;
   reg legal;
   reg [3:0] st_nt;
   reg [3:0] st_tk;
   wire known;
   wire take;
   wire [PC_W-1:0] next_pc;
   wire [PC_W-1:0] target;

   // the flag-compare jumps share their codes with other instructions
   // when the escape byte is absent in binary mode, so they are
   // accepted only with the prefix the current mode demands
   wire esc_ok;
   assign esc_ok = (escaped_i == binary_mode_i);

   always @* begin
      len = `CJX_LEN_REL; // RL2
      rel = byte2_i;
      is_ind = 1'b0;
      is_bitx = 1'b0;
      legal = 1'b0;
      st_nt = `CJX_ST_REL_BIN_NT;
      st_tk = `CJX_ST_REL_BIN_TK;
      case (opcode_i)
         `CJX_OP_EQ, `CJX_OP_GT, `CJX_OP_LE: begin
            legal = esc_ok; // RL1
            st_nt = binary_mode_i ? `CJX_ST_REL_BIN_NT
                                  : `CJX_ST_REL_SRC_NT;
            st_tk = binary_mode_i ? `CJX_ST_REL_BIN_TK
                                  : `CJX_ST_REL_SRC_TK;
         end
         `CJX_OP_CYC: begin
            legal = ~escaped_i; // RL13
            st_nt = `CJX_ST_CYC_NT; // RL13
            st_tk = `CJX_ST_CYC_TK;
         end
         `CJX_OP_IND: begin
            legal = ~escaped_i;
            is_ind = 1'b1;
            len = `CJX_LEN_IND;
            st_nt = `CJX_ST_IND;
            st_tk = `CJX_ST_IND;
         end
         `CJX_OP_BITC: begin
            legal = ~escaped_i; // RL8
            len = `CJX_LEN_BIT; // RL9
            rel = byte3_i; // RL9
            st_nt = `CJX_ST_BIT_NT;
            st_tk = `CJX_ST_BIT_TK;
         end
         `CJX_OP_BITX: begin
            // extended bit form: sub-op in byte two, offset in byte four
            // of the escaped stream, delivered here as byte three
            legal = esc_ok && (byte2_i[7:3] == `CJX_SUB_BITC);
            is_bitx = 1'b1;
            len = binary_mode_i ? `CJX_LEN_BITX_BIN : `CJX_LEN_BITX_SRC;
            rel = byte3_i; // RL9
            st_nt = binary_mode_i ? `CJX_ST_BITX_BIN_NT
                                  : `CJX_ST_BITX_SRC_NT;
            st_tk = binary_mode_i ? `CJX_ST_BITX_BIN_TK
                                  : `CJX_ST_BITX_SRC_TK;
         end
         default: legal = 1'b0;
      endcase
   end

   cjx_cond_eval u_cond (
      .opcode_i(opcode_i),
      .bit_form_i(is_bitx),
      .zero_flag_i(zero_flag_i),
      .carry_flag_i(carry_flag_i),
      .test_bit_i(test_bit_i),
      .known_o(known),
      .take_o(take)
   );

   cjx_target_calc #(
      .PC_W(PC_W)
   ) u_tgt (
      .pc_i(pc_i),
      .len_i(len),
      .rel_i(rel),
      .next_pc_o(next_pc),
      .target_o(target)
   );

   // ****************************************
   // indirect target
   // ****************************************
   // carry out of bit 15 is dropped: the sum wraps within the 64k page
   wire [15:0] ind_low;
   wire [PC_W-1:0] ind_target;
   assign ind_low = data_ptr_i + {8'h00, acc_i}; // RL5
   assign ind_target = {{(PC_W-16){1'b0}} | `CJX_PC_HI_IND,
                        ind_low}; // RL6

   // this group never writes core state; one place makes that plain
   assign flags_we_o = 1'b0; // RL7
   assign acc_we_o = 1'b0; // RL7
   assign data_pointer_we_o = 1'b0; // RL7
   assign bit_we_o = 1'b0; // RL10

   // ****************************************
   // result registers
   // ****************************************
   reg [PC_W-1:0] pc_next;
   reg taken_next;
   reg [3:0] states_next;
   reg handled_next;

   always @* begin
      handled_next = instr_valid_i & legal & known;
      taken_next = 1'b0;
      pc_next = pc_o;
      states_next = 4'h0;
      if (handled_next) begin
         if (is_ind) begin
            taken_next = 1'b1;
            pc_next = ind_target; // RL5
            states_next = st_tk;
         end else if (take) begin
            taken_next = 1'b1;
            pc_next = target; // RL2
            states_next = st_tk;
         end else begin
            pc_next = next_pc; // RL9
            states_next = st_nt;
         end
      end
   end

   // carry is an input only; it has no path back out of here
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         done_o <= 1'b0;
         handled_o <= 1'b0;
         taken_o <= 1'b0;
         pc_o <= {PC_W{1'b0}};
         states_o <= 4'h0;
         pc_load_o <= 1'b0;
      end else begin
         done_o <= instr_valid_i;
         handled_o <= handled_next;
         taken_o <= taken_next;
         pc_o <= pc_next; // RL12
         states_o <= states_next;
         pc_load_o <= handled_next;
      end
   end

endmodule

// file: tb/cjx_exec_sva.sv
// assertion checker for the jump execute unit
`timescale 1ns/100ps
module cjx_exec_sva #(
   parameter PC_W = 24
) (
   // clock, reset, instruction and core state
   input wire sys_clk_i,
   input wire srst_i,
   input wire instr_valid_i,
   input wire binary_mode_i,
   input wire escaped_i,
   input wire [7:0] opcode_i,
   input wire [7:0] byte2_i,
   input wire [7:0] byte3_i,
   input wire [PC_W-1:0] pc_i,
   input wire [7:0] acc_i,
   input wire [15:0] data_ptr_i,
   input wire zero_flag_i,
   input wire carry_flag_i,
   input wire test_bit_i,
   // results
   input wire done_o,
   input wire handled_o,
   input wire taken_o,
   input wire [PC_W-1:0] pc_o,
   input wire [3:0] states_o,
   input wire flags_we_o,
   input wire acc_we_o,
   input wire data_pointer_we_o,
   input wire bit_we_o
);
   // ****
   // checks
   // ****
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   wire rel_ok = instr_valid_i && escaped_i == binary_mode_i;
   wire raw_ok = instr_valid_i && !escaped_i;
   sequence s_ind;
      raw_ok && opcode_i == 8'h73;
   endsequence
   sequence s_bit;
      raw_ok && opcode_i == 8'h30;
   endsequence
   sequence s_rel;
      rel_ok && (opcode_i == 8'hA8 || opcode_i == 8'h38 ||
         opcode_i == 8'h28);
   endsequence
   a_rel_target: assert property (s_rel |=> handled_o &&
      pc_o == $past(pc_i) + 24'h000002 + (taken_o ?
      {{16{$past(byte2_i[7])}}, $past(byte2_i)} : 24'h000000))
      else $error("relative target wrong");
   a_cyc_taken: assert property (
      raw_ok && opcode_i == 8'h50 |=> taken_o == !$past(carry_flag_i))
      else $error("carry-clear outcome wrong");
   a_eq_taken: assert property (
      rel_ok && opcode_i == 8'hA8 |=> taken_o == $past(zero_flag_i))
      else $error("equal branch outcome wrong");
   a_gt_cond: assert property (
      rel_ok && opcode_i == 8'h38 |=>
      taken_o == (!$past(zero_flag_i) && !$past(carry_flag_i)))
      else $error("greater branch outcome wrong");
   a_le_cond: assert property (
      rel_ok && opcode_i == 8'h28 |=>
      taken_o == ($past(zero_flag_i) || $past(carry_flag_i)))
      else $error("less-equal branch outcome wrong");
   a_ind_target: assert property (s_ind |=> taken_o &&
      pc_o == {8'hFF, $past(data_ptr_i) + $past(acc_i)})
      else $error("indirect target wrong");
   a_bit_target: assert property (s_bit |=>
      pc_o == $past(pc_i) + 24'h000003 + (taken_o ? {{16{$past(byte3_i[7])}},
      $past(byte3_i)} : 24'h000000) && taken_o == !$past(test_bit_i))
      else $error("bit-clear target wrong");
   a_cyc_states: assert property (
      raw_ok && opcode_i == 8'h50 |=> handled_o &&
      states_o == ($past(carry_flag_i) ? 4'h1 : 4'h4))
      else $error("carry-clear states wrong");
   a_no_writes: assert property (
      !(flags_we_o || acc_we_o || data_pointer_we_o || bit_we_o))
      else $error("state write enable raised");
   a_idle_hold: assert property (!instr_valid_i |=>
      !done_o && !handled_o && $stable(pc_o))
      else $error("idle cycle disturbed outputs");
   a_done_pulse: assert property (instr_valid_i |=> done_o)
      else $error("done missing");
endmodule
bind cjx_exec cjx_exec_sva #(
   .PC_W(PC_W)
) u_sva (
   .sys_clk_i(sys_clk_i),
   .srst_i(srst_i),
   .instr_valid_i(instr_valid_i),
   .binary_mode_i(binary_mode_i),
   .escaped_i(escaped_i),
   .opcode_i(opcode_i),
   .byte2_i(byte2_i),
   .byte3_i(byte3_i),
   .pc_i(pc_i),
   .acc_i(acc_i),
   .data_ptr_i(data_ptr_i),
   .zero_flag_i(zero_flag_i),
   .carry_flag_i(carry_flag_i),
   .test_bit_i(test_bit_i),
   .done_o(done_o),
   .handled_o(handled_o),
   .taken_o(taken_o),
   .pc_o(pc_o),
   .states_o(states_o),
   .flags_we_o(flags_we_o),
   .acc_we_o(acc_we_o),
   .data_pointer_we_o(data_pointer_we_o),
   .bit_we_o(bit_we_o)
);

// file: tb/tb_cjx_exec.sv
// self-checking bench for the jump execute unit
`timescale 1ns/100ps
module tb_cjx_exec;
   // ****
   // stimulus and model
   // ****
   logic sys_clk_i = 0, srst_i = 1, v = 0, bm = 0, es = 0, z = 0, c = 0;
   logic tbit = 0, done_o, handled_o, taken_o, pc_load_o;
   logic [7:0] op = 0, b2 = 0, b3 = 0, a = 0;
   logic [15:0] dp = 0;
   logic [23:0] pc = 0, pc_o;
   logic [3:0] states_o;
   logic [7:0] tab [8] = '{8'hA8, 8'h38, 8'h28, 8'h73, 8'h30, 8'h50,
      8'hA9, 8'h00};
   int err_count = 0, check_count = 0;
   int i, r, x, e_d = 0, e_h = 0, e_t = 0, e_s = 0, e_pc = 0, rel;
   always #5 sys_clk_i = ~sys_clk_i;
   cjx_exec uut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .instr_valid_i(v),
      .binary_mode_i(bm), .escaped_i(es), .opcode_i(op), .byte2_i(b2),
      .byte3_i(b3), .pc_i(pc), .acc_i(a), .data_ptr_i(dp), .zero_flag_i(z),
      .carry_flag_i(c), .test_bit_i(tbit), .done_o(done_o),
      .handled_o(handled_o), .taken_o(taken_o), .pc_o(pc_o),
      .states_o(states_o), .pc_load_o(pc_load_o), .flags_we_o(),
      .acc_we_o(), .data_pointer_we_o(), .bit_we_o());
   task automatic chk(string n, logic [23:0] s, int x);
      check_count++;
      if (s !== x[23:0]) begin
         err_count++;
         $display("mismatch %s expected %0h seen %0h", n, x[23:0], s);
      end
   endtask
   task automatic print_verdict();
      if (err_count == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // a random opcode byte may fall outside the group: the model refuses it
   task automatic pick();
      logic [7:0] o;
      logic m;
      logic [26:0] rv;
      o = tab[$urandom % 8];
      if (o == 8'h00) o = $urandom;
      m = $urandom;
      rv = $urandom;
      // most extended forms carry the bit-clear sub-op, the rest are refused
      if (o == 8'hA9 && $urandom % 4 != 0) rv[26:22] = 5'h06;
      v <= ($urandom % 8) != 0;
      bm <= m;
      op <= o;
      es <= ($urandom % 5 == 0) ? $urandom :
         ((o == 8'hA8 || o == 8'h38 || o == 8'h28 || o == 8'hA9) && m);
      {b2, b3, a, z, c, tbit} <= rv;
      dp <= (i % 40 == 0) ? 16'hFFFF : $urandom;
      pc <= (i % 50 == 0) ? 24'hFFFFFE : $urandom;
   endtask
   task automatic model();
      // a reset seen at the next edge clears every result and the pc
      if (srst_i) begin
         e_d = 0;
         e_t = 0;
         e_s = 0;
         e_h = 0;
         e_pc = 0;
         return;
      end
      e_d = v;
      e_t = 0;
      e_s = 0;
      e_h = 0;
      r = op == 8'hA8 || op == 8'h38 || op == 8'h28;
      x = op == 8'hA9;
      rel = $signed((op == 8'h30 || x) ? b3 : b2);
      case (op)
         8'hA8: e_t = z;
         8'h38: e_t = !z && !c;
         8'h28: e_t = z || c;
         8'h50: e_t = !c;
         8'h30: e_t = !tbit;
         8'hA9: e_t = !tbit;
         8'h73: e_t = 1;
         default: e_h = -1;
      endcase
      if (!v || e_h < 0 || es !== ((r || x) ? bm : 1'b0) ||
         (x && b2[7:3] != 5'h06)) begin
         e_t = 0;
         e_h = 0;
         return;
      end
      e_h = 1;
      if (op == 8'h73) e_s = 5;
      else if (x) e_s = (e_t ? 3 : 0) + (bm ? 4 : 3);
      else e_s = (e_t ? 3 : 0) + (((r && bm) || op == 8'h30) ? 2 : 1);
      // relative forms advance by two in both modes, escape or not
      if (op == 8'h73) e_pc = 'hFF0000 + ((a + dp) & 'hFFFF);
      else if (x) e_pc = (pc + (bm ? 5 : 4) + (e_t ? rel : 0)) & 'hFFFFFF;
      else e_pc = (pc + (op == 8'h30 ? 3 : 2) + (e_t ? rel : 0)) & 'hFFFFFF;
   endtask
   initial begin
      i = $urandom(97);
      repeat (5) @(posedge sys_clk_i);
      srst_i <= 0;
      for (i = 0; i < 600; i++) begin
         @(posedge sys_clk_i);
         pick();
         // a second reset in mid-run must clear the pulses and the pc
         if (i == 300) srst_i <= 1;
         if (i == 302) srst_i <= 0;
         @(negedge sys_clk_i);
         chk("done", done_o, e_d);
         chk("handled", handled_o, e_h);
         chk("pc_load", pc_load_o, e_h);
         chk("taken", taken_o, e_t);
         chk("states", states_o, e_s);
         chk("pc", pc_o, e_pc);
         model();
      end
      print_verdict();
   end
   initial begin
      #20000;
      err_count++;
      print_verdict();
   end
endmodule
